// [nia_accept.sv]
// nested interrupt acceptance: decides whether a pending request may
// interrupt the running code, keeps the ie/isp status and a save stack.
// assumes all request and sequencer strobes come from core-clock logic.
//
// Behaviour
// - no hardware request accepted while ack-enable flag clear; software requests still taken
// - acknowledging any request clears ack-enable flag
// - enable instruction sets ack-enable flag
// - fixed order plus programmable levels; levels decide
// - equal or higher priority nests when enabled
// - refused requests stay pending, never lost
// - after return, one main instruction before acceptance
// - in-service flag 0 admits only high level and software requests
// - in-service flag 1 admits both levels
// - level bit 0 high, 1 low; four registers
module nia_accept #(
	parameter int NUM_SRC = nia_pkg::NIA_SRC_NUM,
	parameter int STK_DEPTH = nia_pkg::NIA_STK_DEPTH
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [NUM_SRC-1:0] irq_req_i,
	input wire logic [NUM_SRC-1:0] irq_en_i,
	input wire logic swi_req_i,
	input wire logic enable_irq_instruction_i,
	input wire logic disable_irq_instruction_i,
	input wire logic insn_done_i,
	input wire logic irq_return_i,
	input wire logic lvl_wr_i,
	input wire logic [1:0] lvl_sel_i,
	input wire logic [nia_pkg::NIA_REG_W-1:0] lvl_data_i,
	output logic ack_o,
	output logic ack_sw_o,
	output logic [$clog2(NUM_SRC)-1:0] ack_id_o,
	output logic global_ack_enable_flag_o,
	output logic in_service_level_flag_o,
	output logic [NUM_SRC-1:0] pending_o,
	output logic [NUM_SRC-1:0] source_level_bit_o,
	output logic [$clog2(STK_DEPTH+1)-1:0] depth_o
);
	import nia_pkg::*;

	localparam int IDW = $clog2(NUM_SRC);
	localparam int DW = $clog2(STK_DEPTH + 1);
	localparam logic [DW-1:0] DEPTH_FULL = DW'(STK_DEPTH);

	logic ie_q;
	logic isp_q;
	logic hold_q;
	logic swi_pend_q;
	logic ack_q;
	logic ack_sw_q;
	logic [IDW-1:0] ack_id_q;
	logic [NUM_SRC-1:0] pend_q;
	logic [NUM_SRC-1:0] lvl_q;
	logic [DW-1:0] depth_q;
	logic [STK_DEPTH-1:0] save_ie_q;
	logic [STK_DEPTH-1:0] save_isp_q;

	logic [NUM_SRC-1:0] hi_cand;
	logic [NUM_SRC-1:0] lo_cand;
	logic [NUM_SRC-1:0] sel_cand;
	logic [NUM_SRC-1:0] ack_clr;
	logic [IDW-1:0] pick_idx;
	logic stk_full;
	logic stk_empty;
	logic gate_open;
	logic take_sw;
	logic take_hi;
	logic take_lo;
	logic take_any;
	logic do_ret;
	logic [DW-1:0] pop_ptr;
	logic ie_d;
	logic isp_d;

	// level bit 0 is the higher level
	assign hi_cand = pend_q & irq_en_i & ~lvl_q;
	assign lo_cand = pend_q & irq_en_i & lvl_q;

	assign stk_full = (depth_q == DEPTH_FULL);
	assign stk_empty = (depth_q == '0);
	assign do_ret = irq_return_i & ~stk_empty;
	assign pop_ptr = depth_q - DW'(1);

	// a return and a new acceptance never share a cycle, so the
	// restored status is always the one the decision sees
	assign gate_open = ie_q & ~hold_q & ~irq_return_i & ~stk_full;

	// software interrupts are not masked by the ack-enable flag
	assign take_sw = swi_pend_q & ~hold_q & ~irq_return_i & ~stk_full;

	// high level always nests over whatever runs
	assign take_hi = gate_open & (|hi_cand) & ~take_sw;
	// low level only when nothing, a low-level or a software routine runs
	assign take_lo = gate_open & isp_q & (|lo_cand) & ~(|hi_cand) & ~take_sw;
	assign take_any = take_hi | take_lo | take_sw;

	assign sel_cand = take_hi ? hi_cand : lo_cand;

	// fixed order inside one level: lowest source index wins
	always_comb begin
		pick_idx = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (sel_cand[i]) begin
				pick_idx = IDW'(i);
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_src
			assign ack_clr[g] = (take_hi | take_lo) & (pick_idx == IDW'(g));
		end
	endgenerate

	// level registers, one byte per select code
	generate
		for (g = 0; g < NIA_LVL_REGS; g++) begin : g_lvl
			always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					lvl_q[g*NIA_REG_W +: NIA_REG_W] <= NIA_LVL_RST;
				end else if (lvl_wr_i && lvl_sel_i == 2'(g)) begin
					lvl_q[g*NIA_REG_W +: NIA_REG_W] <= lvl_data_i;
				end
			end
		end
	endgenerate

	// a new request in the clearing cycle survives: set wins
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_q <= '0;
			swi_pend_q <= 1'h0;
		end else begin
			pend_q <= (pend_q & ~ack_clr) | irq_req_i;
			swi_pend_q <= (swi_pend_q & ~take_sw) | swi_req_i;
		end
	end

	// ack-enable flag: return restores, acceptance clears, then ei/di
	always_comb begin
		ie_d = ie_q;
		if (do_ret) begin
			ie_d = save_ie_q[pop_ptr[$clog2(STK_DEPTH)-1:0]];
		end else if (take_any) begin
			ie_d = 1'h0;
		end else if (enable_irq_instruction_i) begin
			ie_d = 1'h1;
		end else if (disable_irq_instruction_i) begin
			ie_d = 1'h0;
		end
	end

	// in-service flag follows the accepted source's level
	always_comb begin
		isp_d = isp_q;
		if (do_ret) begin
			isp_d = save_isp_q[pop_ptr[$clog2(STK_DEPTH)-1:0]];
		end else if (take_hi) begin
			isp_d = NIA_LVL_HIGH;
		end else if (take_lo | take_sw) begin
			isp_d = NIA_LVL_LOW;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ie_q <= NIA_IE_RST;
			isp_q <= NIA_ISP_RST;
		end else begin
			ie_q <= ie_d;
			isp_q <= isp_d;
		end
	end

	// status save stack; a full stack refuses further nesting
	generate
		for (g = 0; g < STK_DEPTH; g++) begin : g_stk
			always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					save_ie_q[g] <= NIA_IE_RST;
					save_isp_q[g] <= NIA_ISP_RST;
				end else if (take_any && depth_q == DW'(g)) begin
					save_ie_q[g] <= ie_q;
					save_isp_q[g] <= isp_q;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			depth_q <= '0;
		end else if (do_ret) begin
			depth_q <= pop_ptr;
		end else if (take_any) begin
			depth_q <= depth_q + DW'(1);
		end
	end

	// hold after return until the resumed code retires one instruction;
	// a retire in the return cycle belongs to the routine, so set wins
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_q <= 1'h0;
		end else if (do_ret) begin
			hold_q <= 1'h1;
		end else if (insn_done_i) begin
			hold_q <= 1'h0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'h0;
			ack_sw_q <= 1'h0;
			ack_id_q <= '0;
		end else begin
			ack_q <= take_any;
			ack_sw_q <= take_sw;
			ack_id_q <= take_sw ? '0 : pick_idx;
		end
	end

	assign ack_o = ack_q;
	assign ack_sw_o = ack_sw_q;
	assign ack_id_o = ack_id_q;
	assign global_ack_enable_flag_o = ie_q;
	assign in_service_level_flag_o = isp_q;
	assign pending_o = pend_q;
	assign source_level_bit_o = lvl_q;
	assign depth_o = depth_q;

endmodule // nia_accept

// [nia_pkg.sv]
// nested interrupt acceptance: shared constants
// assumes one core clock domain, no software-visible bus
package nia_pkg;

	// source count: four 8-bit level registers, one bit per source
	localparam int NIA_LVL_REGS = 4;
	localparam int NIA_REG_W = 8;
	localparam int NIA_SRC_NUM = NIA_LVL_REGS * NIA_REG_W;

	// depth of the saved status word stack (nesting levels)
	localparam int NIA_STK_DEPTH = 8;

	// level register select codes
	localparam logic [1:0] NIA_SEL_LVL0_LOW = 2'h0;
	localparam logic [1:0] NIA_SEL_LVL0_HIGH = 2'h1;
	localparam logic [1:0] NIA_SEL_LVL1_LOW = 2'h2;
	localparam logic [1:0] NIA_SEL_LVL1_HIGH = 2'h3;

	// source level bit encoding
	localparam logic NIA_LVL_HIGH = 1'h0;
	localparam logic NIA_LVL_LOW = 1'h1;

	// values after reset
	localparam logic [NIA_REG_W-1:0] NIA_LVL_RST = 8'hff;
	localparam logic NIA_IE_RST = 1'h0;
	localparam logic NIA_ISP_RST = 1'h1;

endpackage : nia_pkg

// [nia_chk.sv]
// nia_accept checker: acknowledge and status flag relations
// bound to nia_accept, sees only its ports
module nia_chk #(parameter int NUM_SRC = 32, parameter int STK_DEPTH = 8) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic enable_irq_instruction_i,
	input wire logic irq_return_i,
	input wire logic ack_o,
	input wire logic ack_sw_o,
	input wire logic [$clog2(NUM_SRC)-1:0] ack_id_o,
	input wire logic global_ack_enable_flag_o,
	input wire logic in_service_level_flag_o,
	input wire logic [NUM_SRC-1:0] pending_o,
	input wire logic [NUM_SRC-1:0] source_level_bit_o,
	input wire logic [$clog2(STK_DEPTH+1)-1:0] depth_o
);
	wire ie = global_ack_enable_flag_o;
	wire in_service_level_flag = in_service_level_flag_o;
	wire mk = ack_o && !ack_sw_o;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_clr; ack_o |-> !ie; endproperty
	a_clr: assert property (p_clr) else $error("ie kept");
	property p_gate; mk |-> $past(ie); endproperty
	a_gate: assert property (p_gate) else $error("ie gate");
	property p_ei; enable_irq_instruction_i && !irq_return_i |=> ie || ack_o; endproperty
	a_ei: assert property (p_ei) else $error("ei");
	property p_lvl; mk |-> in_service_level_flag == source_level_bit_o[ack_id_o]; endproperty
	a_lvl: assert property (p_lvl) else $error("isp load");
	property p_hi; mk && !$past(in_service_level_flag) |-> !in_service_level_flag; endproperty
	a_hi: assert property (p_hi) else $error("low nested");
	property p_dep; ack_o |-> depth_o == $past(depth_o) + 1; endproperty
	a_dep: assert property (p_dep) else $error("depth");
	property p_keep; !ack_o |-> ($past(pending_o) & ~pending_o) == '0; endproperty
	a_keep: assert property (p_keep) else $error("lost");
	property p_hold; irq_return_i && depth_o != 0 |=> !ack_o [*2]; endproperty
	a_hold: assert property (p_hold) else $error("hold");
endmodule // nia_chk
bind nia_accept nia_chk #(.NUM_SRC(NUM_SRC), .STK_DEPTH(STK_DEPTH)) u_chk (.ref_clk_i, .rst_n_i,
	.enable_irq_instruction_i, .irq_return_i, .ack_o, .ack_sw_o, .ack_id_o, .global_ack_enable_flag_o,
	.in_service_level_flag_o, .pending_o, .source_level_bit_o, .depth_o);

// [nia_core_mdl.sv]
// core sequencer model: retires one instruction every 4th cycle
// assumes run_i is held while main code executes
module nia_core_mdl (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	output logic insn_done_o
);
	logic [1:0] cnt_q;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cnt_q <= 2'h0;
		else
			cnt_q <= run_i ? cnt_q + 2'h1 : 2'h0;
	end
	// slow on purpose: hold must outlast the return
	assign insn_done_o = run_i && cnt_q == 2'h2;
endmodule // nia_core_mdl

// [tb_top.sv]
// testbench for nia_accept: flags, nesting, pending hold
// inputs change on falling edges; core model gives retirements
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import nia_pkg::*;
	logic clk = 0, rst_n = 0, swi = 0, ei = 0, di = 0, ret = 0, wr = 0, run = 0, done, ack, asw, ie, in_service_level_flag;
	logic [1:0] sel = 0;
	logic [7:0] dat = 0;
	logic [31:0] req = 0, en = '1, pend, lvl;
	logic [4:0] id;
	logic [3:0] dep;
	int mismatches = 0, total_checks = 0;
	nia_accept DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .irq_req_i(req), .irq_en_i(en), .swi_req_i(swi),
		.enable_irq_instruction_i(ei), .disable_irq_instruction_i(di), .insn_done_i(done), .irq_return_i(ret),
		.lvl_wr_i(wr), .lvl_sel_i(sel), .lvl_data_i(dat), .ack_o(ack), .ack_sw_o(asw), .ack_id_o(id),
		.global_ack_enable_flag_o(ie), .in_service_level_flag_o(in_service_level_flag), .pending_o(pend),
		.source_level_bit_o(lvl), .depth_o(dep));
	nia_core_mdl core (.ref_clk_i(clk), .rst_n_i(rst_n), .run_i(run), .insn_done_o(done));
	initial forever #4 clk = ~clk;
	task automatic cy(int n); repeat (n) @(negedge clk); endtask
	task automatic pl(ref logic s); s = 1; cy(1); s = 0; endtask
	task automatic rq(int k); req[k] = 1; cy(1); req[k] = 0; endtask
	task automatic wack(); for (int i = 0; i < 20 && ack !== 1; i++) cy(1); endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic t_reset();
		chk("ie", NIA_IE_RST, ie);
		chk("isp", NIA_ISP_RST, in_service_level_flag);
		chk("lvl", '1, lvl);
	endtask
	task automatic t_refuse();
		sel = NIA_SEL_LVL0_LOW;
		dat = 8'he7;
		pl(wr);
		rq(3);
		cy(3);
		chk("ack", 0, ack);
		chk("pend", 32'h8, pend);
		chk("lvl", 32'hffffffe7, lvl);
	endtask
	task automatic t_nest();
		en[3] = 1'h0;
		pl(ei);
		cy(3);
		chk("masked", 0, ack);
		en[3] = 1'h1;
		wack();
		chk("id", {5'h3, 1'h0, 1'h0, 4'h1}, {id, ie, in_service_level_flag, dep});
		pl(ei);
		rq(0);
		cy(3);
		chk("low", 1, pend);
		rq(4);
		wack();
		chk("eq", {5'h4, 2'h0, 4'h2}, {id, ie, in_service_level_flag, dep});
		pl(swi);
		wack();
		chk("sw", {1'h1, 4'h3, 1'h1}, {asw, dep, in_service_level_flag});
	endtask
	task automatic t_ret();
		repeat (3) begin
			pl(ret);
			cy(1);
		end
		cy(3);
		chk("hold", {1'h0, 4'h0, 2'h3}, {ack, dep, ie, in_service_level_flag});
		run = 1;
		wack();
		run = 0;
		chk("late", {5'h0, 1'h1, 4'h1}, {id, in_service_level_flag, dep});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cy(5);
		rst_n = 1;
		t_reset();
		t_refuse();
		t_nest();
		t_ret();
		tally_and_finish();
	end
	// about 37 cycles needed, 250 allowed
	initial begin
		#2000;
		mismatches++;
		tally_and_finish();
	end
endmodule // tb_top
